// file: hdl/dbm_top.sv
// Dual bridge control with protection sequencer and APB registers
`timescale 1ns/1ps
`include "dbm_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - While PWM toggles, a bridge with exactly one direction input high alternates between its drive direction (PWM high) and short brake (PWM low).
// - Every swap of conduction within a leg passes through at least 300 ns with both transistors off.
// - Direction reversal or drive/brake changes need no host off time; the internal dead time covers them.
// - An over-temperature trip switches off every output transistor of both bridges.
// - After a thermal shutdown the outputs come back on by themselves once 50 us off time has passed and TEMP_COOL has released the latch.
// - Over-temperature uses hysteresis and clears only when the cool indication shows 40 C below trip.
// - Each transistor's current is watched separately and an overcurrent on any one switches all off.
// - An overcurrent shutdown runs a 50 us timer after which the outputs return with no host action.
// - A fresh overcurrent after re-enable repeats the shutdown, off time and retry, without limit.
// - Overcurrent trips only after the excess persists 10 us continuously; shorter bursts are ignored.
// - The fault flag is high while either current limiter or the thermal shutdown is active, else low.
// - The fault flag returns low by itself when the limiter ends or the thermal condition is released.
module dbm_top #(
  parameter int DEAD_CYC    = `DBM_DEAD_CYC,
  parameter int OC_FILT_CYC = `DBM_OC_FILT_CYC,
  parameter int OFF_CYC     = `DBM_OFF_CYC
) (
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              STANDBY_RELEASE,
  input  wire dbm_pkg::dbm_cmd_s BRIDGE_A_IN,
  input  wire dbm_pkg::dbm_cmd_s BRIDGE_B_IN,
  input  wire logic [7:0]        OC_SENSE,
  input  wire logic              TEMP_TRIP,
  input  wire logic              TEMP_COOL,
  output dbm_pkg::dbm_gate_s     BRIDGE_A_GATE,
  output dbm_pkg::dbm_gate_s     BRIDGE_B_GATE,
  output logic                   FAULT_FLAG_OUT,
  output logic                   IRQ
);
  localparam int TW = $clog2(OFF_CYC + 1);
  localparam logic [TW-1:0] OFF_LOAD = TW'(OFF_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  dbm_pkg::dbm_prot_e      prot_q;
  dbm_pkg::dbm_prot_e      prot_d;
  logic [TW-1:0]           timer_q;
  logic [TW-1:0]           timer_d;
  logic [1:0]              oc_active_q;
  logic [1:0]              oc_active_d;
  logic                    th_latch_q;
  logic [7:0]              oc_tripped;
  logic                    oc_a;
  logic                    oc_b;
  logic                    drive_en;
  logic [`DBM_EV_W-1:0]    ev;
  logic [`DBM_EV_W-1:0]    status_q;
  logic [`DBM_EV_W-1:0]    status_d;
  logic [`DBM_EV_W-1:0]    enable_q;
  logic [`DBM_RETRY_W-1:0] retry_q;
  logic                    access;
  logic                    wr;
  logic                    clr_hit;
  logic [31:0]             rdata;
  logic                    unmapped;

  ////////////////////////////////////////////////////////////////////////////////
  // Bridges

  assign drive_en = (prot_q == dbm_pkg::PROT_RUN);

  dbm_bridge #(
    .DEAD_CYC (DEAD_CYC)
  ) u_bridge_a (
    .clk             (CLK),
    .rst             (RST),
    .drive_en        (drive_en),
    .standby_release (STANDBY_RELEASE),
    .cmd             (BRIDGE_A_IN),
    .gate_q          (BRIDGE_A_GATE)
  );

  dbm_bridge #(
    .DEAD_CYC (DEAD_CYC)
  ) u_bridge_b (
    .clk             (CLK),
    .rst             (RST),
    .drive_en        (drive_en),
    .standby_release (STANDBY_RELEASE),
    .cmd             (BRIDGE_B_IN),
    .gate_q          (BRIDGE_B_GATE)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Overcurrent filters, one per transistor

  // Filters held cleared while off so a retry starts a fresh 10 us window
  for (genvar g = 0; g < 8; g++)
  begin : g_oc
    dbm_glitch_filter #(
      .FILT_CYC (OC_FILT_CYC)
    ) u_filt (
      .clk       (CLK),
      .rst       (RST),
      .hold      (!drive_en),
      .level     (OC_SENSE[g]),
      .tripped_q (oc_tripped[g])
    );
  end

  assign oc_a = |oc_tripped[3:0];
  assign oc_b = |oc_tripped[7:4];

  ////////////////////////////////////////////////////////////////////////////////
  // Thermal hysteresis

  always_ff @(posedge CLK)
  begin
    if (RST)
      th_latch_q <= 1'b0;
    else if (TEMP_TRIP)
      th_latch_q <= 1'b1;
    else if (TEMP_COOL)
      th_latch_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Protection sequencer

  // Thermal outranks overcurrent; timer counts clock cycles, not PWM edges
  always_comb
  begin
    prot_d      = prot_q;
    timer_d     = timer_q;
    oc_active_d = oc_active_q;
    ev          = '0;
    case (prot_q)
      dbm_pkg::PROT_RUN:
      begin
        if (TEMP_TRIP)
        begin
          prot_d                = dbm_pkg::PROT_TH_OFF;
          timer_d               = OFF_LOAD;
          ev[`DBM_EV_THERMAL]   = 1'b1;
        end
        else if (oc_a || oc_b)
        begin
          prot_d                = dbm_pkg::PROT_OC_OFF;
          timer_d               = OFF_LOAD;
          oc_active_d           = {oc_b, oc_a};
          ev[`DBM_EV_OC_A]      = oc_a;
          ev[`DBM_EV_OC_B]      = oc_b;
        end
      end
      dbm_pkg::PROT_OC_OFF:
      begin
        if (TEMP_TRIP)
        begin
          prot_d                = dbm_pkg::PROT_TH_OFF;
          timer_d               = OFF_LOAD;
          oc_active_d           = '0;
          ev[`DBM_EV_THERMAL]   = 1'b1;
        end
        else if (timer_q == '0)
        begin
          prot_d                = dbm_pkg::PROT_RUN;
          oc_active_d           = '0;
          ev[`DBM_EV_REENABLE]  = 1'b1;
        end
        else
          timer_d = timer_q - TW'(1);
      end
      dbm_pkg::PROT_TH_OFF:
      begin
        if (timer_q != '0)
          timer_d = timer_q - TW'(1);
        else if (th_latch_q)
          timer_d = OFF_LOAD;
        else
        begin
          prot_d                = dbm_pkg::PROT_RUN;
          ev[`DBM_EV_REENABLE]  = 1'b1;
        end
      end
      default:
      begin
        prot_d  = dbm_pkg::PROT_TH_OFF;
        timer_d = OFF_LOAD;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      prot_q      <= dbm_pkg::PROT_RUN;
      timer_q     <= '0;
      oc_active_q <= '0;
    end
    else
    begin
      prot_q      <= prot_d;
      timer_q     <= timer_d;
      oc_active_q <= oc_active_d;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      FAULT_FLAG_OUT <= 1'b0;
    else
      FAULT_FLAG_OUT <= (prot_d != dbm_pkg::PROT_RUN) || TEMP_TRIP || th_latch_q;
  end

  // Saturates so a stuck short cannot wrap the count back to zero
  always_ff @(posedge CLK)
  begin
    if (RST)
      retry_q <= '0;
    else if (ev[`DBM_EV_REENABLE] && (retry_q != '1))
      retry_q <= retry_q + `DBM_RETRY_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave

  // One wait state: PREADY rises on the second access cycle
  assign access  = PSEL && PENABLE && PREADY;
  assign wr      = access && PWRITE;
  assign clr_hit = wr && (PADDR == `DBM_ADDR_CLEAR);

  always_comb
  begin
    rdata    = '0;
    unmapped = 1'b0;
    case (PADDR)
      `DBM_ADDR_STATUS: rdata[`DBM_EV_W-1:0] = status_q;
      `DBM_ADDR_CLEAR:  rdata = '0;
      `DBM_ADDR_ENABLE: rdata[`DBM_EV_W-1:0] = enable_q;
      `DBM_ADDR_STATE:
      begin
        rdata[`DBM_ST_FAULT]   = FAULT_FLAG_OUT;
        rdata[`DBM_ST_RUN]     = drive_en;
        rdata[`DBM_ST_OC_A]    = oc_active_q[0];
        rdata[`DBM_ST_OC_B]    = oc_active_q[1];
        rdata[`DBM_ST_THERMAL] = th_latch_q;
      end
      `DBM_ADDR_RETRY:  rdata[`DBM_RETRY_W-1:0] = retry_q;
      default:          unmapped = 1'b1;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PRDATA  <= (PSEL && PENABLE && !PREADY && !PWRITE) ? rdata : '0;
      PSLVERR <= PSEL && PENABLE && !PREADY && unmapped;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      enable_q <= `DBM_ENABLE_RST;
    else if (wr && (PADDR == `DBM_ADDR_ENABLE))
      enable_q <= PWDATA[`DBM_EV_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts

  // New event beats a clear in the same cycle
  always_comb
  begin
    status_d = status_q & ~(clr_hit ? PWDATA[`DBM_EV_W-1:0] : '0);
    status_d = status_d | ev;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      status_q <= '0;
      IRQ      <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      IRQ      <= |(status_d & enable_q);
    end
  end
endmodule : dbm_top

// file: hdl/dbm_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef DBM_REGS_SVH
`define DBM_REGS_SVH

`define DBM_CLK_NS          10
`define DBM_DEAD_NS         300
`define DBM_OC_FILT_NS      10000
`define DBM_OFF_NS          50000
// Least times round up to whole cycles
`define DBM_DEAD_CYC        ((`DBM_DEAD_NS + `DBM_CLK_NS - 1) / `DBM_CLK_NS)
`define DBM_OC_FILT_CYC     ((`DBM_OC_FILT_NS + `DBM_CLK_NS - 1) / `DBM_CLK_NS)
`define DBM_OFF_CYC         ((`DBM_OFF_NS + `DBM_CLK_NS - 1) / `DBM_CLK_NS)

`define DBM_ADDR_STATUS     8'h00
`define DBM_ADDR_CLEAR      8'h04
`define DBM_ADDR_ENABLE     8'h08
`define DBM_ADDR_STATE      8'h0C
`define DBM_ADDR_RETRY      8'h10

`define DBM_EV_W            4
`define DBM_EV_OC_A         0
`define DBM_EV_OC_B         1
`define DBM_EV_THERMAL      2
`define DBM_EV_REENABLE     3
`define DBM_ENABLE_RST      4'h0

`define DBM_ST_FAULT        0
`define DBM_ST_RUN          1
`define DBM_ST_OC_A         2
`define DBM_ST_OC_B         3
`define DBM_ST_THERMAL      4
`define DBM_RETRY_W         16

`endif

// file: hdl/dbm_pkg.sv
// Types shared by the bridge control design
package dbm_pkg;

  typedef enum logic [1:0] {
    LEG_OFF  = 2'b00,
    LEG_HIGH = 2'b01,
    LEG_LOW  = 2'b10
  } dbm_leg_e;

  typedef enum logic [1:0] {
    PROT_RUN    = 2'b00,
    PROT_OC_OFF = 2'b01,
    PROT_TH_OFF = 2'b10
  } dbm_prot_e;

  typedef struct packed {
    logic direction_in_a;
    logic direction_in_b;
    logic pwm;
  } dbm_cmd_s;

  typedef struct packed {
    logic leg1_hi;
    logic leg1_lo;
    logic leg2_hi;
    logic leg2_lo;
  } dbm_gate_s;

endpackage : dbm_pkg

// file: hdl/dbm_glitch_filter.sv
// Persistence filter for one transistor's overcurrent sense
`timescale 1ns/1ps
`include "dbm_regs.svh"
module dbm_glitch_filter #(
  parameter int FILT_CYC = `DBM_OC_FILT_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic hold,
  input  wire logic level,
  output logic      tripped_q
);
  localparam int CW = $clog2(FILT_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(FILT_CYC - 1);
  localparam logic [CW-1:0] FULL = CW'(FILT_CYC);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk)
  begin
    if (rst || hold || !level)
      cnt_q <= '0;
    else if (cnt_q != FULL)
      cnt_q <= cnt_q + CW'(1);
  end

  // Any low sample restarts the count
  always_ff @(posedge clk)
  begin
    if (rst || hold)
      tripped_q <= 1'b0;
    else
      tripped_q <= level && (cnt_q >= LAST);
  end
endmodule : dbm_glitch_filter

// file: hdl/dbm_bridge.sv
// One full bridge: input decode and per-leg dead time
`timescale 1ns/1ps
`include "dbm_regs.svh"
module dbm_bridge #(
  parameter int DEAD_CYC = `DBM_DEAD_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              drive_en,
  input  wire logic              standby_release,
  input  wire dbm_pkg::dbm_cmd_s cmd,
  output dbm_pkg::dbm_gate_s     gate_q
);
  localparam int CW = $clog2(DEAD_CYC + 1);

  dbm_pkg::dbm_leg_e want [2];
  dbm_pkg::dbm_leg_e leg_q [2];
  dbm_pkg::dbm_leg_e leg_d [2];
  logic [CW-1:0]     cnt_q [2];
  logic [CW-1:0]     cnt_d [2];

  always_comb
  begin
    if (!drive_en || !standby_release || (!cmd.direction_in_a && !cmd.direction_in_b))
    begin
      want[0] = dbm_pkg::LEG_OFF;
      want[1] = dbm_pkg::LEG_OFF;
    end
    else if ((cmd.direction_in_a && cmd.direction_in_b) || !cmd.pwm)
    begin
      want[0] = dbm_pkg::LEG_LOW;
      want[1] = dbm_pkg::LEG_LOW;
    end
    else if (cmd.direction_in_a)
    begin
      want[0] = dbm_pkg::LEG_HIGH;
      want[1] = dbm_pkg::LEG_LOW;
    end
    else
    begin
      want[0] = dbm_pkg::LEG_LOW;
      want[1] = dbm_pkg::LEG_HIGH;
    end
  end

  // Leaving conduction always passes through off for DEAD_CYC+1 cycles
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      leg_d[i] = leg_q[i];
      cnt_d[i] = (cnt_q[i] != '0) ? cnt_q[i] - CW'(1) : cnt_q[i];
      if (want[i] != leg_q[i])
      begin
        if (leg_q[i] != dbm_pkg::LEG_OFF)
        begin
          leg_d[i] = dbm_pkg::LEG_OFF;
          cnt_d[i] = CW'(DEAD_CYC);
        end
        else if (cnt_q[i] == '0)
          leg_d[i] = want[i];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (rst)
      begin
        leg_q[i] <= dbm_pkg::LEG_OFF;
        cnt_q[i] <= '0;
      end
      else
      begin
        leg_q[i] <= leg_d[i];
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      gate_q <= '0;
    else
    begin
      gate_q.leg1_hi <= (leg_d[0] == dbm_pkg::LEG_HIGH);
      gate_q.leg1_lo <= (leg_d[0] == dbm_pkg::LEG_LOW);
      gate_q.leg2_hi <= (leg_d[1] == dbm_pkg::LEG_HIGH);
      gate_q.leg2_lo <= (leg_d[1] == dbm_pkg::LEG_LOW);
    end
  end
endmodule : dbm_bridge

// file: bench/dbm_top_monitor.sv
// Port-level property checker for the bridge control top
`timescale 1ns/1ps
module dbm_top_monitor #(
  parameter int OC_FILT_CYC = 20,
  parameter int OFF_CYC     = 50
) (
  input wire logic               CLK,
  input wire logic               RST,
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic               PREADY,
  input wire logic               STANDBY_RELEASE,
  input wire dbm_pkg::dbm_cmd_s  BRIDGE_A_IN,
  input wire dbm_pkg::dbm_cmd_s  BRIDGE_B_IN,
  input wire logic [7:0]         OC_SENSE,
  input wire dbm_pkg::dbm_gate_s BRIDGE_A_GATE,
  input wire dbm_pkg::dbm_gate_s BRIDGE_B_GATE,
  input wire logic               FAULT_FLAG_OUT
);
  default clocking dc @(posedge CLK); endclocking
  default disable iff (RST);
  logic [3:0]  st_a_q;
  logic [3:0]  st_b_q;
  logic [7:0]  oc_q;
  logic [15:0] fl_q;
  logic [7:0]  gv;
  assign gv = {BRIDGE_A_GATE, BRIDGE_B_GATE};
  ////////////////////////////////////////////////////////////
  function automatic logic [3:0] dec(logic sb, dbm_pkg::dbm_cmd_s c);
    if (!sb || !(c.direction_in_a || c.direction_in_b))
      return 4'h0;
    if ((c.direction_in_a && c.direction_in_b) || !c.pwm)
      return 4'h5;
    return c.direction_in_a ? 4'h9 : 4'h6;
  endfunction : dec
  // Decode judged only after dead time has surely run out
  always_ff @(posedge CLK)
    if (RST || FAULT_FLAG_OUT || !$stable({STANDBY_RELEASE, BRIDGE_A_IN}))
      st_a_q <= 4'h0;
    else if (st_a_q != 4'hF)
      st_a_q <= st_a_q + 4'h1;
  always_ff @(posedge CLK)
    if (RST || FAULT_FLAG_OUT || !$stable({STANDBY_RELEASE, BRIDGE_B_IN}))
      st_b_q <= 4'h0;
    else if (st_b_q != 4'hF)
      st_b_q <= st_b_q + 4'h1;
  always_ff @(posedge CLK)
    oc_q <= (RST || OC_SENSE == 8'h00) ? 8'h00 : oc_q + {7'h00, oc_q != 8'hFF};
  always_ff @(posedge CLK)
    fl_q <= (RST || !FAULT_FLAG_OUT) ? 16'h0000 : fl_q + 16'h0001;
  a_no_shoot: assert property ((gv & (gv >> 1) & 8'h55) == 8'h00)
    else $error("leg conducts high and low");
  a_dead_gap: assert property ($fell(BRIDGE_A_GATE.leg1_hi) |-> !BRIDGE_A_GATE.leg1_lo [*4])
    else $error("dead gap short");
  a_decode_a: assert property (st_a_q == 4'h8 |-> BRIDGE_A_GATE == dec(STANDBY_RELEASE, BRIDGE_A_IN))
    else $error("bridge A decode");
  a_decode_b: assert property (st_b_q == 4'h8 |-> BRIDGE_B_GATE == dec(STANDBY_RELEASE, BRIDGE_B_IN))
    else $error("bridge B decode");
  a_fault_off: assert property ($rose(FAULT_FLAG_OUT) |-> ##[1:3] (gv == 8'h00) [*8])
    else $error("gates on during fault");
  a_oc_trip: assert property (!FAULT_FLAG_OUT && oc_q == 8'(OC_FILT_CYC) |-> ##[1:2] FAULT_FLAG_OUT)
    else $error("overcurrent not tripped");
  a_off_span: assert property ($fell(FAULT_FLAG_OUT) |-> fl_q >= 16'(OFF_CYC))
    else $error("off time short");
  a_apb_wait: assert property (PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY)
    else $error("wait state wrong");
endmodule : dbm_top_monitor

bind dbm_top dbm_top_monitor #(.OC_FILT_CYC(OC_FILT_CYC), .OFF_CYC(OFF_CYC)) u_dbm_top_monitor (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .STANDBY_RELEASE(STANDBY_RELEASE), .BRIDGE_A_IN(BRIDGE_A_IN), .BRIDGE_B_IN(BRIDGE_B_IN),
  .OC_SENSE(OC_SENSE), .BRIDGE_A_GATE(BRIDGE_A_GATE), .BRIDGE_B_GATE(BRIDGE_B_GATE),
  .FAULT_FLAG_OUT(FAULT_FLAG_OUT));

// file: bench/dbm_host_model.sv
// Host side model: standby, direction and speed PWM drive
`timescale 1ns/1ps
module dbm_host_model #(
  parameter int HALF = 200
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         go,
  input  wire logic [1:0]   dir_a,
  input  wire logic [1:0]   dir_b,
  output logic              sb,
  output dbm_pkg::dbm_cmd_s a_cmd,
  output dbm_pkg::dbm_cmd_s b_cmd
);
  logic [15:0] cnt_q;
  logic        pwm_q;
  ////////////////////////////////////////////////////////////
  // Phases last HALF cycles, never under the 2 us minimum
  always_ff @(posedge clk)
    cnt_q <= (rst || cnt_q == 16'(HALF - 1)) ? 16'h0000 : cnt_q + 16'h0001;
  always_ff @(posedge clk)
    pwm_q <= rst ? 1'b0 : pwm_q ^ (cnt_q == 16'(HALF - 1));
  // Standby low through reset so bridges start idle
  assign sb = go && !rst;
  // Direction flips go straight through, no off gap added
  assign a_cmd = '{dir_a[1], dir_a[0], pwm_q};
  assign b_cmd = '{dir_b[1], dir_b[0], pwm_q};
endmodule : dbm_host_model

// file: bench/dbm_top_tb_top.sv
// Self-checking bench for the dual bridge control block
`timescale 1ns/1ps
module dbm_top_tb_top;
  logic               CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic               TEMP_TRIP, TEMP_COOL, FAULT_FLAG_OUT, IRQ, STANDBY_RELEASE, go;
  logic [1:0]         dir_a, dir_b;
  logic [7:0]         PADDR, OC_SENSE, slv;
  logic [31:0]        PWDATA, PRDATA, rd;
  dbm_pkg::dbm_cmd_s  BRIDGE_A_IN, BRIDGE_B_IN;
  dbm_pkg::dbm_gate_s BRIDGE_A_GATE, BRIDGE_B_GATE;
  int                 err_total, num_checks;
  localparam logic [1:0] DTAB [5] = '{2'h2, 2'h1, 2'h3, 2'h0, 2'h2};
  localparam logic [7:0] HTAB [5] = '{8'h95, 8'h65, 8'h55, 8'h05, 8'h00};
  localparam logic [7:0] LTAB [5] = '{8'h55, 8'h55, 8'h55, 8'h05, 8'h00};
  dbm_top #(.DEAD_CYC(4), .OC_FILT_CYC(20), .OFF_CYC(50)) u_dbm_top (
    .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .STANDBY_RELEASE(STANDBY_RELEASE), .BRIDGE_A_IN(BRIDGE_A_IN), .BRIDGE_B_IN(BRIDGE_B_IN),
    .OC_SENSE(OC_SENSE), .TEMP_TRIP(TEMP_TRIP), .TEMP_COOL(TEMP_COOL), .BRIDGE_A_GATE(BRIDGE_A_GATE),
    .BRIDGE_B_GATE(BRIDGE_B_GATE), .FAULT_FLAG_OUT(FAULT_FLAG_OUT), .IRQ(IRQ));
  dbm_host_model u_dbm_host_model (.clk(CLK), .rst(RST), .go(go), .dir_a(dir_a), .dir_b(dir_b),
    .sb(STANDBY_RELEASE), .a_cmd(BRIDGE_A_IN), .b_cmd(BRIDGE_B_IN));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Waits for PREADY however long it takes; the watchdog ends a hang
    do
    begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1);
    chk("apb wait", 8'h02, 8'(n));
    rd = PRDATA;
    slv = {7'h00, PSLVERR};
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : apb
  task automatic t_regs();
    chk("idle flag", 8'h00, {7'h00, FAULT_FLAG_OUT});
    chk("idle gates", 8'h00, {BRIDGE_A_GATE, BRIDGE_B_GATE});
    apb(1'b0, 8'h08, 32'h0);
    chk("enable rst", 8'h00, rd[7:0]);
    apb(1'b1, 8'h08, 32'h0000000F);
    apb(1'b0, 8'h08, 32'h0);
    chk("enable", 8'h0F, rd[7:0]);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 8'h01, slv);
  endtask : t_regs
  task automatic t_pwm();
    for (int i = 0; i < 5; i++)
    begin
      go    <= (i != 4);
      dir_a <= DTAB[i];
      repeat (2)
      begin
        @(BRIDGE_A_IN.pwm);
        repeat (10) @(posedge CLK);
        chk("gates", BRIDGE_A_IN.pwm ? HTAB[i] : LTAB[i], {BRIDGE_A_GATE, BRIDGE_B_GATE});
      end
    end
  endtask : t_pwm
  task automatic t_oc();
    go       <= 1'b1;
    OC_SENSE <= 8'h04;
    repeat (15) @(posedge CLK);
    OC_SENSE <= 8'h00;
    repeat (5) @(posedge CLK);
    chk("glitch", 8'h00, {7'h00, FAULT_FLAG_OUT});
    OC_SENSE <= 8'h20;
    repeat (24) @(posedge CLK);
    chk("oc flag", 8'h01, {7'h00, FAULT_FLAG_OUT});
    chk("oc gates", 8'h00, {BRIDGE_A_GATE, BRIDGE_B_GATE});
    chk("oc irq", 8'h01, {7'h00, IRQ});
    apb(1'b0, 8'h0C, 32'h0);
    chk("oc state", 8'h09, rd[7:0]);
    repeat (200) @(posedge CLK);
    apb(1'b0, 8'h10, 32'h0);
    chk("retries", 8'h01, {7'h00, rd[15:0] >= 16'h0002});
    OC_SENSE <= 8'h00;
    repeat (80) @(posedge CLK);
    chk("oc back", 8'h00, {7'h00, FAULT_FLAG_OUT});
    apb(1'b0, 8'h00, 32'h0);
    chk("oc status", 8'h0A, rd[7:0]);
    apb(1'b1, 8'h08, 32'h0);
    // IRQ follows a new mask one cycle after the write lands
    @(posedge CLK);
    chk("masked", 8'h00, {7'h00, IRQ});
    apb(1'b1, 8'h04, 32'h0000000F);
    apb(1'b1, 8'h08, 32'h0000000F);
    apb(1'b0, 8'h00, 32'h0);
    chk("cleared", 8'h00, rd[7:0]);
    chk("irq off", 8'h00, {7'h00, IRQ});
  endtask : t_oc
  task automatic t_therm();
    TEMP_TRIP <= 1'b1;
    repeat (5) @(posedge CLK);
    chk("th flag", 8'h01, {7'h00, FAULT_FLAG_OUT});
    chk("th gates", 8'h00, {BRIDGE_A_GATE, BRIDGE_B_GATE});
    repeat (60) @(posedge CLK);
    TEMP_TRIP <= 1'b0;
    repeat (60) @(posedge CLK);
    chk("th hold", 8'h01, {7'h00, FAULT_FLAG_OUT});
    apb(1'b0, 8'h0C, 32'h0);
    chk("th state", 8'h11, rd[7:0]);
    TEMP_COOL <= 1'b1;
    repeat (120) @(posedge CLK);
    TEMP_COOL <= 1'b0;
    chk("th back", 8'h00, {7'h00, FAULT_FLAG_OUT});
    chk("th run", 8'h01, {7'h00, BRIDGE_A_GATE != 4'h0});
    chk("th irq", 8'h01, {7'h00, IRQ});
    apb(1'b0, 8'h00, 32'h0);
    chk("th status", 8'h0C, rd[7:0]);
  endtask : t_therm
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // Whole run is a few thousand cycles
  initial
  begin
    #100us;
    err_total++;
    tally_and_finish();
  end
  initial
  begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    OC_SENSE = 8'h00;
    TEMP_TRIP = 1'b0;
    TEMP_COOL = 1'b0;
    go = 1'b0;
    dir_a = 2'h0;
    dir_b = 2'h3;
    err_total = 0;
    num_checks = 0;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    t_regs();
    t_pwm();
    t_oc();
    t_therm();
    tally_and_finish();
  end
endmodule : dbm_top_tb_top
